//--- bench/mfw_check_sva.sv
`timescale 1ns/1ps
module mfw_check #(
  parameter [15:0] PART_REF   = 16'h0000,
  parameter [15:0] MODULE_VER = 16'h0001
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        clkEn,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic [7:0]  busAddr,
  input wire logic [31:0] busWdata,
  input wire logic [31:0] busRdata,
  input wire logic        busReady,
  input wire logic        fullDuplexSetting,
  input wire logic        externalMatchEnable,
  input wire logic        hashMatchEvent,
  input wire logic        firstSpecificMatchEvent,
  input wire logic        magicPacketEvent,
  input wire logic        arpRequestEvent,
  input wire logic        copyFrame,
  input wire logic        pauseSend,
  input wire logic [15:0] pauseQuantumOut,
  input wire logic        wakeOut
);
  logic        magicEn;
  logic        zq;
  logic [15:0] ip;
  logic [15:0] qnt;
  // Shadow of the written fields; a frozen cycle takes no write
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      magicEn <= 1'b0;
      zq    <= 1'b0;
      ip    <= 16'hffff;
      qnt   <= 16'hffff;
    end
    else if (busWrite && clkEn)
    begin
      if (busAddr == 8'hc4)
      begin
        magicEn <= busWdata[16];
        ip    <= busWdata[15:0];
      end
      if (busAddr == 8'hc0)
        zq <= busWdata[3];
      if (busAddr == 8'hbc)
        qnt <= busWdata[15:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  AST_READY: assert property (clkEn && (busRead || busWrite) |=> busReady)
    else $error("no ready after strobe");
  AST_HALF_DUPLEX: assert property (busRead && busAddr == 8'hc0 |=> busRdata[17] == !$past(fullDuplexSetting))
    else $error("half duplex view wrong");
  AST_VER: assert property (busRead && busAddr == 8'hfc |=> busRdata == {PART_REF, MODULE_VER})
    else $error("revision word wrong");
  AST_MAGIC: assert property (magicPacketEvent && magicEn |=> wakeOut)
    else $error("enabled event gave no wake");
  AST_NOWAKE: assert property (!(hashMatchEvent || firstSpecificMatchEvent || magicPacketEvent || arpRequestEvent)
    |=> !wakeOut)
    else $error("wake without event");
  AST_ARP0: assert property (arpRequestEvent && ip == 16'h0000 && !magicPacketEvent && !hashMatchEvent
    && !firstSpecificMatchEvent |=> !wakeOut)
    else $error("zero address compare woke");
  AST_PAUSE: assert property (pauseSend |-> ($past(busWrite, 2) && $past(busAddr, 2) == 8'hc0) ##1 !pauseSend)
    else $error("pause frame without toggle write");
  AST_ZQ: assert property (pauseSend |-> pauseQuantumOut == (zq ? 16'h0000 : qnt))
    else $error("pause quantum wrong");
  AST_EXT_MATCH: assert property (!externalMatchEnable [*2] |-> !copyFrame)
    else $error("copy without enable");
  CV_PAUSE: cover property (pauseSend);
  CV_WAKE: cover property (wakeOut);
  CV_COPY: cover property (copyFrame);
endmodule // mfw_check

//--- bench/mfw_phy_model.sv
`timescale 1ns/1ps
module mfw_phy_model (
  output logic       phyRxClk,
  output logic       phyRxDv,
  output logic [3:0] phyRxd
);
  initial
  begin
    phyRxClk = 1'b0;
    phyRxDv  = 1'b0;
    phyRxd   = 4'h0;
  end
  task automatic pulse(input int half);
    #half phyRxClk = 1'b1;
    #half phyRxClk = 1'b0;
  endtask
  // Clock stands still between frames; idle data is inverted so it never looks held
  task automatic sendFrame(input int n, input logic [3:0] first, input int half);
    for (int i = 0; i < n; i++)
    begin
      phyRxDv = 1'b1;
      phyRxd  = first + i[3:0];
      pulse(half);
    end
    phyRxDv = 1'b0;
    phyRxd  = ~phyRxd;
    pulse(half);
  endtask
endmodule // mfw_phy_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam [15:0] PREF = 16'h0a5c; // Arbitrary value
  localparam [15:0] PVER = 16'h0003; // Arbitrary value
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [7:0] busAddr = 8'h00;
  logic [31:0] busWdata = 32'h0;
  logic [3:0] cfg = 4'h0;
  logic externalMatchEnable = 1'b0;
  logic [3:0] evts = 4'h0;
  logic [15:0] arpTargetIp = 16'h0;
  logic rxAddrValid = 1'b0;
  logic [47:0] rxDestAddr = 48'h0;
  logic rxTypeValid = 1'b0;
  logic [15:0] rxTypeField = 16'h0;
  logic rxNibbleReady = 1'b1;
  wire [31:0] busRdata;
  wire [15:0] pauseQuantumOut;
  wire [3:0] rxNibble, phyRxd;
  wire busReady, rxNibbleValid, rxFrameEnd, rxOverflow, sa4Match, typeMatch;
  wire copyFrame, pauseSend, rmiiMode, wakeOut, phyRxClk, phyRxDv;
  int pauseCount = 0, wakes = 0, sa4s = 0, types = 0, cycles = 0, mismatches = 0, comparisons = 0, w;
  logic [15:0] lastQ = 16'h0;
  logic [4:0] q[$];
  logic [31:0] d;
  logic [7:0] adr [8] = '{8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hc0, 8'hc4, 8'hfc, 8'h80};
  logic [31:0] rst [8] = '{0, 0, 0, 32'hffff, 32'h20000, 32'hffff, {PREF, PVER}, 0};
  logic [31:0] back [8] = '{32'hffffffff, 32'hffff, 32'hffff, 32'hffff, 32'h2000f, 32'hfffff, {PREF, PVER}, 0};
  logic [63:0] probe [3] = '{64'hffffffffffffffff, 64'hfffffffffffefffe, 64'h7fffffffffff7fff};

  mfw_filter_pause_wake #(.PART_REF(PREF), .MODULE_VER(PVER)) mfw_filter_pause_wake_i (
    .sys_clk, .reset, .clkEn, .busWrite, .busRead, .busAddr, .busWdata, .busRdata, .busReady,
    .speedSetting(cfg[3]), .bitrateSetting(cfg[2]), .fullDuplexSetting(cfg[1]), .loopbackSetting(cfg[0]),
    .externalMatchEnable, .rxAddrValid, .rxDestAddr, .rxTypeValid, .rxTypeField,
    .magicPacketEvent(evts[0]), .arpRequestEvent(evts[1]), .firstSpecificMatchEvent(evts[2]),
    .hashMatchEvent(evts[3]), .arpTargetIp, .phyRxClk, .phyRxDv, .phyRxd, .rxNibbleValid,
    .rxNibbleReady, .rxNibble, .rxFrameEnd, .rxOverflow, .sa4Match, .typeMatch, .copyFrame,
    .pauseSend, .pauseQuantumOut, .rmiiMode, .wakeOut);
  mfw_phy_model mfw_phy_model_i (.phyRxClk, .phyRxDv, .phyRxd);

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    pauseCount += pauseSend;
    wakes += wakeOut;
    sa4s += sa4Match;
    types += typeMatch;
    if (pauseSend)
      lastQ = pauseQuantumOut;
    if (rxNibbleValid && rxNibbleReady)
      q.push_back({rxFrameEnd, rxNibble});
    if (cycles == 20000)
    begin
      mismatches++;
      conclude;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge sys_clk);
    {busAddr, busWdata, busWrite} = {a, v, 1'b1};
    @(negedge sys_clk);
    busWrite = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge sys_clk);
    {busAddr, busRead} = {a, 1'b1};
    @(negedge sys_clk);
    busRead = 1'b0;
    v = busRdata;
    chk(busReady, 1);
  endtask
  task fire(input logic [3:0] v);
    @(negedge sys_clk);
    evts = v;
    @(negedge sys_clk);
    evts = 4'h0;
    repeat (2) @(negedge sys_clk);
  endtask
  task conclude;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      rd(adr[k], d);
      chk(d, rst[k]);
      wr(adr[k], 32'hffffffff);
      rd(adr[k], d);
      chk(d, back[k]);
    end
    chk(pauseCount, 1);
    chk(lastQ, 0);
    chk(rmiiMode, 1);
    for (int k = 0; k < 16; k++)
    begin
      cfg = k[3:0];
      rd(8'hc0, d);
      chk(d[19:16], {cfg[3:2], ~cfg[1], cfg[0]});
    end
    wr(8'hbc, 32'h1234);
    wr(8'hc0, 32'h1);
    repeat (4) @(negedge sys_clk);
    chk(pauseCount, 2);
    chk(lastQ, 16'h1234);
    wr(8'hc0, 32'h1);
    repeat (4) @(negedge sys_clk);
    chk(pauseCount, 2);
    // Frozen clock enable: a write is neither taken nor answered
    clkEn = 1'b0;
    wr(8'hbc, 32'h5555);
    chk(busReady, 0);
    clkEn = 1'b1;
    rd(8'hbc, d);
    chk(d, 32'h1234);
    wr(8'hc0, 32'h2);
    externalMatchEnable = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(copyFrame, 1);
    chk(rmiiMode, 0);
    externalMatchEnable = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(copyFrame, 0);
    // Filters: exact match, then the first and then the last bit off by one
    for (int k = 0; k < 3; k++)
    begin
      {rxDestAddr, rxTypeField} = probe[k];
      @(negedge sys_clk);
      {rxAddrValid, rxTypeValid} = 2'b11;
      @(negedge sys_clk);
      {rxAddrValid, rxTypeValid} = 2'b00;
    end
    @(negedge sys_clk);
    chk(sa4s, 1);
    chk(types, 1);
    arpTargetIp = 16'h0042;
    wr(8'hc4, 32'h42);
    fire(4'hf);
    chk(wakes, 0);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'hc4, (32'h10000 << k) | 32'h42);
      fire(4'h1 << k);
      chk(wakes, k + 1);
    end
    rd(8'hc0, d);
    chk(d[20], 1);
    wr(8'hc0, 32'h100002);
    rd(8'hc0, d);
    chk(d[20], 0);
    wr(8'hc4, 32'h20042);
    arpTargetIp = 16'h0043;
    fire(4'h2);
    wr(8'hc4, 32'h20000);
    arpTargetIp = 16'h0000;
    fire(4'h2);
    chk(wakes, 4);
    mfw_phy_model_i.sendFrame(4, 4'h3, 80);
    repeat (10) @(negedge sys_clk);
    chk(q.size(), 5);
    chk(q[4][4], 1);
    for (int k = 0; k < 4; k++)
      chk(q[k], 5'h3 + k);
    // Consumer stalls: one nibble waits in the output stage, sixteen fill the buffer, the rest are refused
    rxNibbleReady = 1'b0;
    q.delete();
    mfw_phy_model_i.sendFrame(18, 4'h0, 80);
    repeat (10) @(negedge sys_clk);
    chk(rxOverflow, 1);
    rxNibbleReady = 1'b1;
    repeat (40) @(negedge sys_clk);
    w = q.size();
    chk(w, 17);
    for (int k = 0; k < 16; k++)
      chk(q[k], k);
    conclude;
  end
endmodule // tb_top

bind mfw_filter_pause_wake mfw_check #(.PART_REF(PART_REF), .MODULE_VER(MODULE_VER)) mfw_check_i (
  .sys_clk, .reset, .clkEn, .busWrite, .busRead, .busAddr, .busWdata, .busRdata, .busReady, .fullDuplexSetting,
  .externalMatchEnable, .hashMatchEvent, .firstSpecificMatchEvent, .magicPacketEvent, .arpRequestEvent,
  .copyFrame, .pauseSend, .pauseQuantumOut, .wakeOut);

//--- rtl/mfw_filter_pause_wake.v
`timescale 1ns/1ps
`include "mfw_regs.vh"

// Small synchronous FIFO; storage is flip-flops indexed by pointer
module mfw_fifo #(
  parameter WIDTH = 5,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk,
  input  wire             reset,
  input  wire             clkEn,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            doPush;
  wire            doPop;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always @(posedge sys_clk)
  begin
    if (clkEn && doPush)
    begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (clkEn)
    begin
      if (doPush)
      begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
        count <= count + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // mfw_fifo

module mfw_filter_pause_wake #(
  parameter [15:0] PART_REF    = 16'h0000,
  parameter [15:0] MODULE_VER  = 16'h0001,
  parameter        FIFO_DEPTH  = `MFW_FIFO_DEPTH
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        clkEn,
  input  wire        busWrite,
  input  wire        busRead,
  input  wire [7:0]  busAddr,
  input  wire [31:0] busWdata,
  output reg  [31:0] busRdata,
  output reg         busReady,
  input  wire        speedSetting,
  input  wire        bitrateSetting,
  input  wire        fullDuplexSetting,
  input  wire        loopbackSetting,
  input  wire        externalMatchEnable,
  input  wire        rxAddrValid,
  input  wire [47:0] rxDestAddr,
  input  wire        rxTypeValid,
  input  wire [15:0] rxTypeField,
  input  wire        hashMatchEvent,
  input  wire        firstSpecificMatchEvent,
  input  wire        magicPacketEvent,
  input  wire        arpRequestEvent,
  input  wire [15:0] arpTargetIp,
  input  wire        phyRxClk,
  input  wire        phyRxDv,
  input  wire [3:0]  phyRxd,
  output reg         rxNibbleValid,
  input  wire        rxNibbleReady,
  output reg  [3:0]  rxNibble,
  output reg         rxFrameEnd,
  output reg         rxOverflow,
  output reg         sa4Match,
  output reg         typeMatch,
  output reg         copyFrame,
  output reg         pauseSend,
  output reg  [15:0] pauseQuantumOut,
  output reg         rmiiMode,
  output reg         wakeOut
);
  // Register state
  reg  [31:0] specificAddress4Low;
  reg  [15:0] specificAddress4High;
  reg  [15:0] typeFieldCompare;
  reg  [15:0] pauseQuantumValue;
  reg         zeroPauseSelect;
  reg         pauseSendToggle;
  reg         pauseToggleSeen;
  reg         externalMatchInput;
  reg         rmiiSelect;
  reg         wakeOnLanIndication;
  reg  [19:0] wakeEventConfig;

  // Link sampling
  reg  [5:0]  linkSync1;
  reg  [5:0]  linkSync2;
  reg         linkClkPrev;
  reg         linkDvPrev;

  wire        wrStrobe;
  wire        rdStrobe;
  wire [15:0] arpCompareValue;
  wire        arpIpHit;
  wire        hashWake;
  wire        firstMatchWake;
  wire        arpWake;
  wire        magicWake;
  wire        anyWake;
  wire        clearWake;
  wire        linkRise;
  wire        pushValid;
  wire        pushReady;
  wire        fifoValid;
  wire [4:0]  fifoData;
  wire        fifoPop;
  wire [31:0] userIoView;
  reg  [31:0] next_rdata;

  assign wrStrobe = busWrite & clkEn;
  assign rdStrobe = busRead & clkEn;

  // Register file writes; all register access runs on the peripheral clock
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      specificAddress4Low  <= `MFW_RST_SA4_LOW;
      specificAddress4High <= `MFW_RST_SA4_HIGH;
      typeFieldCompare     <= `MFW_RST_TYPE_CMP;
      pauseQuantumValue    <= `MFW_RST_PAUSE_QNT;
      zeroPauseSelect      <= 1'b0;
      pauseSendToggle      <= 1'b0;
      externalMatchInput   <= 1'b0;
      rmiiSelect           <= 1'b0;
      wakeEventConfig      <= `MFW_RST_WAKE_CFG;
    end
    else if (wrStrobe)
    begin
      case (busAddr)
        `MFW_OFS_SA4_LOW:
        begin
          specificAddress4Low <= busWdata;
        end
        `MFW_OFS_SA4_HIGH:
        begin
          specificAddress4High <= busWdata[15:0];
        end
        `MFW_OFS_TYPE_CMP:
        begin
          typeFieldCompare <= busWdata[15:0];
        end
        `MFW_OFS_PAUSE_QNT:
        begin
          pauseQuantumValue <= busWdata[15:0];
        end
        `MFW_OFS_USER_IO:
        begin
          zeroPauseSelect    <= busWdata[`MFW_UIO_ZERO_PAUSE];
          pauseSendToggle    <= busWdata[`MFW_UIO_PAUSE_TGL];
          externalMatchInput <= busWdata[`MFW_UIO_EXT_MATCH];
          rmiiSelect         <= busWdata[`MFW_UIO_RMII];
        end
        `MFW_OFS_WAKE_CFG:
        begin
          wakeEventConfig <= busWdata[19:0];
        end
        default:
        begin
          wakeEventConfig <= wakeEventConfig;
        end
      endcase
    end
  end

  // Wake sources; a zero compare value disables the ARP address path
  assign arpCompareValue = wakeEventConfig[15:0];
  assign arpIpHit = (arpCompareValue != 16'h0000)
                  & (arpTargetIp == arpCompareValue);
  assign hashWake = hashMatchEvent & wakeEventConfig[`MFW_WK_HASH];
  assign firstMatchWake = firstSpecificMatchEvent & wakeEventConfig[`MFW_WK_FIRST_SPEC];
  assign arpWake = arpRequestEvent & arpIpHit & wakeEventConfig[`MFW_WK_ARP];
  assign magicWake = magicPacketEvent & wakeEventConfig[`MFW_WK_MAGIC];
  assign anyWake = hashWake | firstMatchWake | arpWake | magicWake;
  assign clearWake = wrStrobe & (busAddr == `MFW_OFS_USER_IO) & busWdata[`MFW_UIO_WAKE_SEEN];

  // Sticky detect; a new event in the clearing cycle wins over the clear
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      wakeOnLanIndication <= 1'b0;
      wakeOut             <= 1'b0;
    end
    else if (clkEn)
    begin
      wakeOut <= anyWake;
      if (anyWake)
      begin
        wakeOnLanIndication <= 1'b1;
      end
      else if (clearWake)
      begin
        wakeOnLanIndication <= 1'b0;
      end
    end
  end

  // Pause frame request on each toggle of the send bit
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      pauseToggleSeen <= 1'b0;
      pauseSend       <= 1'b0;
      pauseQuantumOut <= `MFW_RST_PAUSE_QNT;
    end
    else if (clkEn)
    begin
      pauseToggleSeen <= pauseSendToggle;
      pauseSend       <= pauseSendToggle ^ pauseToggleSeen;
      if (pauseSendToggle ^ pauseToggleSeen)
      begin
        pauseQuantumOut <= zeroPauseSelect ? 16'h0000 : pauseQuantumValue;
      end
    end
  end

  // Receive side filters and settings driven out of the register bank
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      sa4Match  <= 1'b0;
      typeMatch <= 1'b0;
      copyFrame <= 1'b0;
      rmiiMode  <= 1'b0;
    end
    else if (clkEn)
    begin
      // Bit 0 of the low word lines up with the first bit on the wire
      sa4Match  <= rxAddrValid
                 & (rxDestAddr == {specificAddress4High, specificAddress4Low});
      typeMatch <= rxTypeValid & (rxTypeField == typeFieldCompare);
      copyFrame <= externalMatchInput & externalMatchEnable;
      rmiiMode  <= rmiiSelect;
    end
  end

  // Read view of the user I/O word; mirrors track their sources live
  assign userIoView = {11'h000, wakeOnLanIndication, speedSetting, bitrateSetting,
                       ~fullDuplexSetting, loopbackSetting, 12'h000,
                       zeroPauseSelect, pauseSendToggle, externalMatchInput, rmiiSelect};

  always @*
  begin
    next_rdata = 32'h00000000;
    case (busAddr)
      `MFW_OFS_SA4_LOW:   next_rdata = specificAddress4Low;
      `MFW_OFS_SA4_HIGH:  next_rdata = {16'h0000, specificAddress4High};
      `MFW_OFS_TYPE_CMP:  next_rdata = {16'h0000, typeFieldCompare};
      `MFW_OFS_PAUSE_QNT: next_rdata = {16'h0000, pauseQuantumValue};
      `MFW_OFS_USER_IO:   next_rdata = userIoView;
      `MFW_OFS_WAKE_CFG:  next_rdata = {12'h000, wakeEventConfig};
      `MFW_OFS_REVISION:  next_rdata = {PART_REF, MODULE_VER};
      default:            next_rdata = 32'h00000000;
    endcase
  end

  // Register port answers one cycle after a strobe; unmapped reads give zero
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      busRdata <= 32'h00000000;
      busReady <= 1'b0;
    end
    else if (clkEn)
    begin
      busReady <= busRead | busWrite;
      if (rdStrobe)
      begin
        busRdata <= next_rdata;
      end
    end
  end

  // PHY pins cross by two flops; the link clock is sampled, not used as a clock.
  // Sampling at 10 ns is safe only while the link clock stays well below 50 MHz.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      linkSync1   <= 6'h00;
      linkSync2   <= 6'h00;
      linkClkPrev <= 1'b0;
      linkDvPrev  <= 1'b0;
    end
    else if (clkEn)
    begin
      linkSync1 <= {phyRxClk, phyRxDv, phyRxd};
      linkSync2 <= linkSync1;
      linkClkPrev <= linkSync2[5];
      if (linkRise)
      begin
        linkDvPrev <= linkSync2[4];
      end
    end
  end

  assign linkRise  = linkSync2[5] & ~linkClkPrev;
  // Nibble plus an end marker; end of frame is the fall of data valid
  assign pushValid = linkRise & (linkSync2[4] | linkDvPrev);

  mfw_fifo #(
    .WIDTH (5),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_rxFifo (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .clkEn    (clkEn),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   ({~linkSync2[4], linkSync2[3:0]}),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // A PHY cannot be stalled, so a full buffer drops the nibble and flags it
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      rxOverflow <= 1'b0;
    end
    else if (clkEn && pushValid && !pushReady)
    begin
      rxOverflow <= 1'b1;
    end
  end

  // Output stage keeps the stream ports straight from flops
  assign fifoPop = fifoValid & (~rxNibbleValid | rxNibbleReady);

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      rxNibbleValid <= 1'b0;
      rxNibble      <= 4'h0;
      rxFrameEnd    <= 1'b0;
    end
    else if (clkEn)
    begin
      if (~rxNibbleValid | rxNibbleReady)
      begin
        rxNibbleValid <= fifoValid;
        rxNibble      <= fifoData[3:0];
        rxFrameEnd    <= fifoData[4];
      end
    end
  end
endmodule // mfw_filter_pause_wake

//--- shared/mfw_regs.vh
`ifndef MFW_REGS_VH
`define MFW_REGS_VH

`define MFW_OFS_SA4_LOW     8'hb0
`define MFW_OFS_SA4_HIGH    8'hb4
`define MFW_OFS_TYPE_CMP    8'hb8
`define MFW_OFS_PAUSE_QNT   8'hbc
`define MFW_OFS_USER_IO     8'hc0
`define MFW_OFS_WAKE_CFG    8'hc4
`define MFW_OFS_REVISION    8'hfc

`define MFW_RST_SA4_LOW     32'h00000000
`define MFW_RST_SA4_HIGH    16'h0000
`define MFW_RST_TYPE_CMP    16'h0000
`define MFW_RST_PAUSE_QNT   16'hffff
`define MFW_RST_WAKE_CFG    20'h0ffff

`define MFW_UIO_RMII        0
`define MFW_UIO_EXT_MATCH   1
`define MFW_UIO_PAUSE_TGL   2
`define MFW_UIO_ZERO_PAUSE  3
`define MFW_UIO_LOOPBACK    16
`define MFW_UIO_HALF_DUPLEX 17
`define MFW_UIO_BITRATE     18
`define MFW_UIO_SPEED       19
`define MFW_UIO_WAKE_SEEN   20

`define MFW_WK_MAGIC        16
`define MFW_WK_ARP          17
`define MFW_WK_FIRST_SPEC   18
`define MFW_WK_HASH         19

`define MFW_FIFO_DEPTH      16

`endif
